// file: cmr_pkg.sv
// Operation
// RQ1: Every channel has 32 mailboxes, each usable in both receive modes.
// RQ2: With several matching mailboxes the frame goes to the lowest-numbered one.
// RQ3: Normal receive mailbox takes data and remote frames matching its masked identifier.
// RQ4: One-shot mailboxes sharing an identifier fill from lowest upward, skipping full ones.
// RQ5: Overwrite mode replaces an unread frame and sets reception complete.
// RQ6: Overwriting while reception complete is 1 sets message lost.
// RQ7: Overrun mode discards the new frame, sets message lost, raises overrun interrupt.
// RQ8: One-shot mailbox holding a frame accepts nothing more, never reports loss.
// RQ9: Clearing request, complete and lost flags in one write aborts reception.
// RQ10: Software waits for abort completion before clearing the one-shot enable.
// RQ11: Software requests reception only when control reads zero and no abort runs.
// RQ12: In overwrite mode software rechecks reception complete after reading a frame.
// RQ13: Layout select chooses normal or FIFO mailbox layout during configuration.
// RQ14: Normal layout makes every mailbox an ordinary mailbox.
// RQ15: FIFO layout: 0-23 ordinary, 24-27 transmit FIFO, 28-31 receive FIFO.
// RQ16: Storing a frame sets reception complete; only a software zero clears it.
package cmr_pkg;

   localparam int          NUM_MB       = 32;
   localparam int          IDX_W        = 5;
   localparam int          ID_W         = 29;
   localparam int          DATA_W       = 64;
   localparam int          DLC_W        = 4;
   localparam int          CTL_W        = 8;
   localparam int          NUM_MASK     = 8;
   localparam int          MASK_IDX_W   = 3;
   localparam int          MASK_SHIFT   = 2;

   // Layout boundaries
   localparam int          ORD_LAST     = 23;
   localparam int          TXF_FIRST    = 24;
   localparam int          RXF_FIRST    = 28;
   localparam int          RXF_SECOND   = 29;
   localparam int          RXF_MASK_A   = 6;
   localparam int          RXF_MASK_B   = 7;

   // Control byte field positions
   localparam int          CTL_COMPLETE = 0;
   localparam int          CTL_LOST     = 1;
   localparam int          CTL_ABORTING = 2;
   localparam int          CTL_SINGLE_SHOT_ENABLE  = 4;
   localparam int          CTL_TXREQ    = 6;
   localparam int          CTL_RXREQ    = 7;

   localparam logic [7:0]  CTL_IDLE     = 8'h00;

   typedef enum logic {
      LAYOUT_NORMAL,
      LAYOUT_FIFO
   } cmr_layout_t;

   typedef enum logic {
      LOST_OVERWRITE,
      LOST_OVERRUN
   } cmr_lost_t;

endpackage

// file: cmr_mbox_slot.sv
`timescale 1ns/1ps
`default_nettype none
module cmr_mbox_slot (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   // Software control write
   input  wire logic                    ctlWr,
   input  wire logic [cmr_pkg::CTL_W-1:0] ctlData,
   // Bus and match events
   input  wire logic                    rxBusy,
   input  wire logic                    storeHit,
   input  wire logic                    lostHit,
   // Flags
   output logic                         rxReq,
   output logic                         txReq,
   output logic                         singleShot,
   output logic                         rxComplete,
   output logic                         msg_lost_flag,
   output logic                         abortBusy
);

   logic rxReq_q, rxReq_d;
   logic txReq_q, txReq_d;
   logic single_shot_enable_q, single_shot_enable_d;
   logic complete_q, complete_d;
   logic lost_q, lost_d;
   logic abort_q, abort_d;
   logic abortReq;

   always_comb begin
      abortReq = ctlWr & rxReq_q & ~ctlData[cmr_pkg::CTL_RXREQ]
                 & ~ctlData[cmr_pkg::CTL_COMPLETE] & ~ctlData[cmr_pkg::CTL_LOST]; // [RQ9]
      // Abort waits out a frame in flight
      abort_d    = (abortReq | abort_q) & rxBusy; // [RQ9]
      rxReq_d    = ctlWr ? ctlData[cmr_pkg::CTL_RXREQ] : rxReq_q;
      txReq_d    = ctlWr ? ctlData[cmr_pkg::CTL_TXREQ] : txReq_q;
      single_shot_enable_d  = ctlWr ? ctlData[cmr_pkg::CTL_SINGLE_SHOT_ENABLE] : single_shot_enable_q;
      // Hardware set wins over software clear
      complete_d = storeHit
                   | (complete_q & ~(ctlWr & ~ctlData[cmr_pkg::CTL_COMPLETE])); // [RQ16]
      lost_d     = lostHit
                   | (lost_q & ~(ctlWr & ~ctlData[cmr_pkg::CTL_LOST])); // [RQ6] [RQ7]
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxReq_q    <= 1'b0;
         txReq_q    <= 1'b0;
         single_shot_enable_q  <= 1'b0;
         complete_q <= 1'b0;
         lost_q     <= 1'b0;
         abort_q    <= 1'b0;
      end else begin
         rxReq_q    <= rxReq_d;
         txReq_q    <= txReq_d;
         single_shot_enable_q  <= single_shot_enable_d;
         complete_q <= complete_d;
         lost_q     <= lost_d;
         abort_q    <= abort_d;
      end
   end

   assign rxReq      = rxReq_q;
   assign txReq      = txReq_q;
   assign singleShot = single_shot_enable_q;
   assign rxComplete = complete_q;
   assign msg_lost_flag    = lost_q;
   assign abortBusy  = abort_q;

endmodule
`default_nettype wire

// file: cmr_rx_mailbox.sv
`timescale 1ns/1ps
`default_nettype none
module cmr_rx_mailbox (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   // Channel configuration
   input  wire logic                          mailboxLayoutSel,
   input  wire logic                          lostMsgModeSel,
   input  wire logic                          overrunIntEnable,
   // Mailbox control register write
   input  wire logic                          ctlWrEn,
   input  wire logic [cmr_pkg::IDX_W-1:0]     ctlWrIdx,
   input  wire logic [cmr_pkg::CTL_W-1:0]     ctlWrData,
   // Mailbox identifier write
   input  wire logic                          idWrEn,
   input  wire logic [cmr_pkg::IDX_W-1:0]     idWrIdx,
   input  wire logic [cmr_pkg::ID_W-1:0]      idWrData,
   input  wire logic                          idWrExt,
   // Acceptance mask write
   input  wire logic                          maskWrEn,
   input  wire logic [cmr_pkg::MASK_IDX_W-1:0] maskWrIdx,
   input  wire logic [cmr_pkg::ID_W-1:0]      maskWrData,
   // Received frame from protocol engine
   input  wire logic                          rxBusy,
   input  wire logic                          frmValid,
   input  wire logic [cmr_pkg::ID_W-1:0]      frmId,
   input  wire logic                          frmExt,
   input  wire logic                          frmRemote,
   input  wire logic [cmr_pkg::DLC_W-1:0]     frmDlc,
   input  wire logic [cmr_pkg::DATA_W-1:0]    frmData,
   // Mailbox read port
   input  wire logic [cmr_pkg::IDX_W-1:0]     rdIdx,
   output logic [cmr_pkg::CTL_W-1:0]          rdCtl,
   output logic [cmr_pkg::DATA_W-1:0]         rdData,
   output logic [cmr_pkg::DLC_W-1:0]          rdDlc,
   output logic                               rdRemote,
   // Reception events
   output logic                               storeValid,
   output logic [cmr_pkg::IDX_W-1:0]          storeIdx,
   output logic                               lostEvent,
   output logic                               overrunIrq,
   output logic                               fifoRxValid,
   // Flag vectors
   output logic [cmr_pkg::NUM_MB-1:0]         rxCompleteVec,
   output logic [cmr_pkg::NUM_MB-1:0]         msgLostVec,
   output logic [cmr_pkg::NUM_MB-1:0]         abortBusyVec
);

   localparam int N = cmr_pkg::NUM_MB;

   // Per-mailbox flags
   logic [N-1:0] rxReqV;
   logic [N-1:0] txReqV;
   logic [N-1:0] oneShotV;
   logic [N-1:0] completeV;
   logic [N-1:0] lostV;
   logic [N-1:0] abortV;
   logic [N-1:0] ctlWrV;
   logic [N-1:0] storeHitV;
   logic [N-1:0] lostHitV;
   logic [N-1:0] candV;

   // Identifier, mask and frame storage
   logic [cmr_pkg::ID_W-1:0]   mbId_q    [N];
   logic [cmr_pkg::ID_W-1:0]   mbId_d    [N];
   logic                       mbExt_q   [N];
   logic                       mbExt_d   [N];
   logic [cmr_pkg::ID_W-1:0]   mask_q    [cmr_pkg::NUM_MASK];
   logic [cmr_pkg::ID_W-1:0]   mask_d    [cmr_pkg::NUM_MASK];
   logic [cmr_pkg::DATA_W-1:0] mbData_q  [N];
   logic [cmr_pkg::DATA_W-1:0] mbData_d  [N];
   logic [cmr_pkg::DLC_W-1:0]  mbDlc_q   [N];
   logic [cmr_pkg::DLC_W-1:0]  mbDlc_d   [N];
   logic                       mbRemote_q[N];
   logic                       mbRemote_d[N];

   // Selection results
   logic                       found;
   logic [cmr_pkg::IDX_W-1:0]  win;
   logic                       winFull;
   logic                       winNormal;
   logic                       discard;
   logic                       doStore;
   logic                       doLose;
   logic                       fifoHit;

   // Event registers
   logic                       storeValid_q, storeValid_d;
   logic [cmr_pkg::IDX_W-1:0]  storeIdx_q, storeIdx_d;
   logic                       lostEvent_q, lostEvent_d;
   logic                       overrun_q, overrun_d;
   logic                       fifoRx_q, fifoRx_d;

   // Read port registers
   logic [cmr_pkg::CTL_W-1:0]  rdCtl_q, rdCtl_d;
   logic [cmr_pkg::DATA_W-1:0] rdData_q, rdData_d;
   logic [cmr_pkg::DLC_W-1:0]  rdDlc_q, rdDlc_d;
   logic                       rdRemote_q, rdRemote_d;

   function automatic logic idMatch(
      input logic [cmr_pkg::ID_W-1:0] rxId,
      input logic                     rxExt,
      input logic [cmr_pkg::ID_W-1:0] boxId,
      input logic                     boxExt,
      input logic [cmr_pkg::ID_W-1:0] mask
   );
      // Mask bit 1 means the identifier bit is compared
      idMatch = (((rxId ^ boxId) & mask) == '0) && (rxExt == boxExt);
   endfunction

   // One flag slot per mailbox
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gSlot // [RQ1]
         assign ctlWrV[g] = ctlWrEn && (ctlWrIdx == cmr_pkg::IDX_W'(g));
         cmr_mbox_slot uSlot (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .ctlWr      (ctlWrV[g]),
            .ctlData    (ctlWrData),
            .rxBusy     (rxBusy),
            .storeHit   (storeHitV[g]),
            .lostHit    (lostHitV[g]),
            .rxReq      (rxReqV[g]),
            .txReq      (txReqV[g]),
            .singleShot (oneShotV[g]),
            .rxComplete (completeV[g]),
            .msg_lost_flag    (lostV[g]),
            .abortBusy  (abortV[g])
         );
      end
   endgenerate

   // Candidate mailboxes for the incoming frame
   always_comb begin
      logic eligible;
      logic hit;
      eligible = 1'b0;
      hit      = 1'b0;
      candV    = '0;
      for (int j = 0; j < N; j++) begin
         eligible = (mailboxLayoutSel == cmr_pkg::LAYOUT_NORMAL) // [RQ13] [RQ14]
                    || (j <= cmr_pkg::ORD_LAST); // [RQ15]
         // Data and remote frames alike
         hit      = idMatch(frmId, frmExt, mbId_q[j], mbExt_q[j],
                            mask_q[j >> cmr_pkg::MASK_SHIFT]); // [RQ3]
         // Full one-shot box steps aside
         candV[j] = frmValid && rxReqV[j] && !txReqV[j] && !abortV[j] && eligible && hit
                    && !(oneShotV[j] && completeV[j]); // [RQ4] [RQ8]
      end
   end

   // Lowest-numbered candidate wins
   always_comb begin
      found = 1'b0;
      win   = '0;
      for (int j = 0; j < N; j++) begin
         if (candV[j] && !found) begin // [RQ2] [RQ4]
            found = 1'b1;
            win   = cmr_pkg::IDX_W'(j);
         end
      end
   end

   // Overwrite or overrun decision
   always_comb begin
      winFull   = completeV[win];
      winNormal = !oneShotV[win];
      discard   = found && winNormal && winFull
                  && (lostMsgModeSel == cmr_pkg::LOST_OVERRUN); // [RQ7]
      doStore   = found && !discard; // [RQ5]
      doLose    = found && winNormal && winFull; // [RQ6] [RQ7] [RQ8]
      storeHitV = '0;
      lostHitV  = '0;
      storeHitV[win] = doStore; // [RQ16]
      lostHitV[win]  = doLose;
   end

   // Frames for the receive FIFO when no ordinary box takes them
   always_comb begin
      fifoHit = frmValid && !found && (mailboxLayoutSel == cmr_pkg::LAYOUT_FIFO) // [RQ15]
                && (idMatch(frmId, frmExt, mbId_q[cmr_pkg::RXF_FIRST],
                            mbExt_q[cmr_pkg::RXF_FIRST], mask_q[cmr_pkg::RXF_MASK_A])
                    || idMatch(frmId, frmExt, mbId_q[cmr_pkg::RXF_SECOND],
                               mbExt_q[cmr_pkg::RXF_SECOND], mask_q[cmr_pkg::RXF_MASK_B]));
   end

   // Identifier and mask next values
   always_comb begin
      for (int j = 0; j < N; j++) begin
         mbId_d[j]  = mbId_q[j];
         mbExt_d[j] = mbExt_q[j];
      end
      for (int k = 0; k < cmr_pkg::NUM_MASK; k++) begin
         mask_d[k] = mask_q[k];
      end
      if (idWrEn) begin
         mbId_d[idWrIdx]  = idWrData;
         mbExt_d[idWrIdx] = idWrExt;
      end
      if (maskWrEn) begin
         mask_d[maskWrIdx] = maskWrData;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int j = 0; j < N; j++) begin
            mbId_q[j]  <= '0;
            mbExt_q[j] <= 1'b0;
         end
         for (int k = 0; k < cmr_pkg::NUM_MASK; k++) begin
            mask_q[k] <= '0;
         end
      end else begin
         for (int j = 0; j < N; j++) begin
            mbId_q[j]  <= mbId_d[j];
            mbExt_q[j] <= mbExt_d[j];
         end
         for (int k = 0; k < cmr_pkg::NUM_MASK; k++) begin
            mask_q[k] <= mask_d[k];
         end
      end
   end

   // Frame storage next values
   always_comb begin
      for (int j = 0; j < N; j++) begin
         mbData_d[j]   = mbData_q[j];
         mbDlc_d[j]    = mbDlc_q[j];
         mbRemote_d[j] = mbRemote_q[j];
      end
      if (doStore) begin // [RQ5]
         mbData_d[win]   = frmData;
         mbDlc_d[win]    = frmDlc;
         mbRemote_d[win] = frmRemote;
      end
   end

   // Frame storage, no reset needed
   always_ff @(posedge ref_clk) begin
      for (int j = 0; j < N; j++) begin
         mbData_q[j]   <= mbData_d[j];
         mbDlc_q[j]    <= mbDlc_d[j];
         mbRemote_q[j] <= mbRemote_d[j];
      end
   end

   // Event next values
   always_comb begin
      storeValid_d = doStore;
      storeIdx_d   = doStore ? win : storeIdx_q;
      lostEvent_d  = doLose;
      overrun_d    = discard && overrunIntEnable; // [RQ7]
      fifoRx_d     = fifoHit;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         storeValid_q <= 1'b0;
         storeIdx_q   <= '0;
         lostEvent_q  <= 1'b0;
         overrun_q    <= 1'b0;
         fifoRx_q     <= 1'b0;
      end else begin
         storeValid_q <= storeValid_d;
         storeIdx_q   <= storeIdx_d;
         lostEvent_q  <= lostEvent_d;
         overrun_q    <= overrun_d;
         fifoRx_q     <= fifoRx_d;
      end
   end

   // Read port next values
   always_comb begin
      rdCtl_d = cmr_pkg::CTL_IDLE;
      rdCtl_d[cmr_pkg::CTL_COMPLETE] = completeV[rdIdx];
      rdCtl_d[cmr_pkg::CTL_LOST]     = lostV[rdIdx];
      rdCtl_d[cmr_pkg::CTL_ABORTING] = abortV[rdIdx];
      rdCtl_d[cmr_pkg::CTL_SINGLE_SHOT_ENABLE]  = oneShotV[rdIdx];
      rdCtl_d[cmr_pkg::CTL_TXREQ]    = txReqV[rdIdx];
      rdCtl_d[cmr_pkg::CTL_RXREQ]    = rxReqV[rdIdx];
      rdData_d   = mbData_q[rdIdx];
      rdDlc_d    = mbDlc_q[rdIdx];
      rdRemote_d = mbRemote_q[rdIdx];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdCtl_q    <= cmr_pkg::CTL_IDLE;
         rdData_q   <= '0;
         rdDlc_q    <= '0;
         rdRemote_q <= 1'b0;
      end else begin
         rdCtl_q    <= rdCtl_d;
         rdData_q   <= rdData_d;
         rdDlc_q    <= rdDlc_d;
         rdRemote_q <= rdRemote_d;
      end
   end

   assign rdCtl         = rdCtl_q;
   assign rdData        = rdData_q;
   assign rdDlc         = rdDlc_q;
   assign rdRemote      = rdRemote_q;
   assign storeValid    = storeValid_q;
   assign storeIdx      = storeIdx_q;
   assign lostEvent     = lostEvent_q;
   assign overrunIrq    = overrun_q;
   assign fifoRxValid   = fifoRx_q;
   assign rxCompleteVec = completeV;
   assign msgLostVec    = lostV;
   assign abortBusyVec  = abortV;

endmodule
`default_nettype wire

// file: cmr_rx_mailbox_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cmr_rx_mailbox_assertions (
   // Watched ports
   input wire logic                        ref_clk,
   input wire logic                        rst,
   input wire logic                        mailboxLayoutSel,
   input wire logic                        lostMsgModeSel,
   input wire logic                        overrunIntEnable,
   input wire logic                        ctlWrEn,
   input wire logic                        rxBusy,
   input wire logic                        frmValid,
   input wire logic                        storeValid,
   input wire logic [cmr_pkg::IDX_W-1:0]   storeIdx,
   input wire logic                        lostEvent,
   input wire logic                        overrunIrq,
   input wire logic [cmr_pkg::NUM_MB-1:0]  rxCompleteVec,
   input wire logic [cmr_pkg::NUM_MB-1:0]  msgLostVec,
   input wire logic [cmr_pkg::NUM_MB-1:0]  abortBusyVec
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_store_has_frame: assert property (storeValid |-> $past(frmValid))
      else $error("store without a frame");
   a_store_sets_flag: assert property (storeValid |-> rxCompleteVec[storeIdx])
      else $error("stored box has no complete flag");
   a_flag_sw_clear: assert property (
      (|($past(rxCompleteVec) & ~rxCompleteVec)) |-> $past(ctlWrEn))
      else $error("complete flag fell without a write");
   a_lost_has_frame: assert property (
      (|(msgLostVec & ~$past(msgLostVec))) |-> $past(frmValid) && lostEvent)
      else $error("lost flag rose without a frame");
   a_irq_when_overrun: assert property (
      overrunIrq |-> $past(overrunIntEnable) && $past(lostMsgModeSel) && !storeValid)
      else $error("overrun interrupt out of place");
   a_overwrite_stores: assert property (lostEvent && !$past(lostMsgModeSel) |-> storeValid)
      else $error("overwrite did not store");
   a_fifo_keeps_top: assert property (
      storeValid && $past(mailboxLayoutSel) |-> storeIdx <= cmr_pkg::ORD_LAST)
      else $error("FIFO box took an ordinary frame");
   a_abort_start: assert property (
      (|(abortBusyVec & ~$past(abortBusyVec))) |-> $past(ctlWrEn) && $past(rxBusy))
      else $error("abort began without a write during reception");
   a_abort_ends: assert property ((|abortBusyVec) && !rxBusy |=> abortBusyVec == '0)
      else $error("abort did not end");
   c_store: cover property (storeValid);
   c_irq: cover property (overrunIrq);
   c_abort: cover property (|abortBusyVec);
endmodule
bind cmr_rx_mailbox cmr_rx_mailbox_assertions i_cmr_rx_mailbox_assertions (.ref_clk, .rst,
   .mailboxLayoutSel, .lostMsgModeSel, .overrunIntEnable, .ctlWrEn, .rxBusy, .frmValid,
   .storeValid, .storeIdx, .lostEvent, .overrunIrq, .rxCompleteVec, .msgLostVec, .abortBusyVec);
`default_nettype wire

// file: cmr_can_node_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmr_can_node_model (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   // Frame order from bench
   input  wire logic                        go,
   input  wire logic [cmr_pkg::ID_W-1:0]    goId,
   input  wire logic [cmr_pkg::DATA_W-1:0]  goData,
   input  wire logic                        goRemote,
   input  wire logic [3:0]                  goLen,
   // Frame towards the mailboxes
   output logic                             rxBusy,
   output logic                             frmValid,
   output logic [cmr_pkg::ID_W-1:0]         frmId,
   output logic                             frmExt,
   output logic                             frmRemote,
   output logic [cmr_pkg::DLC_W-1:0]        frmDlc,
   output logic [cmr_pkg::DATA_W-1:0]       frmData
);
   logic [3:0] cnt;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {rxBusy, frmValid, frmExt, frmRemote, cnt} <= '0;
         {frmId, frmDlc, frmData} <= '0;
      end else if (go) begin
         rxBusy <= 1'b1;
         cnt <= goLen;
      end else if (rxBusy && cnt <= 4'h1) begin
         // Data or remote frame ends here
         {rxBusy, frmValid, frmExt} <= 3'b010;
         {frmId, frmRemote, frmDlc, frmData} <= {goId, goRemote, 4'h8, goData};
      end else begin
         // Fields are stale outside a frame
         cnt <= cnt - 4'h1;
         frmValid <= 1'b0;
         {frmId, frmExt, frmRemote, frmDlc, frmData}
            <= ~{frmId, frmExt, frmRemote, frmDlc, frmData};
      end
   end
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [28:0] ID_A = 29'h0000123, ID_B = 29'h1ABCDE0, ID_C = 29'h0000777;
   localparam logic [28:0] ID_E = 29'h0000E0E, ID_F = 29'h0000F0F;
   logic ref_clk = 1'b0, rst = 1'b1, layout = 1'b0, lostMode = 1'b0, irqEn = 1'b0;
   logic ctlWrEn = 1'b0, idWrEn = 1'b0, maskWrEn = 1'b0, go = 1'b0, goRemote = 1'b0;
   logic [4:0] ctlWrIdx = '0, idWrIdx = '0, rdIdx = '0, storeIdx;
   logic [7:0] ctlWrData = '0, rdCtl;
   logic [2:0] maskWrIdx = '0;
   logic [28:0] idWrData = '0, goId = '0, frmId, maskData = 29'h1FFFFFFF;
   logic [63:0] goData = '0, frmData, rdData;
   logic [3:0] goLen = 4'h1, frmDlc, rdDlc;
   logic rxBusy, frmValid, frmExt, frmRemote, rdRemote, storeValid, lostEvent, overrunIrq, fifoRx;
   logic [31:0] rxCompleteVec, msgLostVec, abortBusyVec;
   int failures = 0, n_tests = 0;
   always #5 ref_clk = ~ref_clk;
   cmr_can_node_model i_cmr_can_node_model (.ref_clk, .rst, .go, .goId, .goData, .goRemote,
      .goLen, .rxBusy, .frmValid, .frmId, .frmExt, .frmRemote, .frmDlc, .frmData);
   cmr_rx_mailbox i_cmr_rx_mailbox (.ref_clk, .rst, .mailboxLayoutSel(layout),
      .lostMsgModeSel(lostMode), .overrunIntEnable(irqEn), .ctlWrEn, .ctlWrIdx, .ctlWrData,
      .idWrEn, .idWrIdx, .idWrData, .idWrExt(1'b0), .maskWrEn, .maskWrIdx,
      .maskWrData(maskData), .rxBusy, .frmValid, .frmId, .frmExt, .frmRemote, .frmDlc,
      .frmData, .rdIdx, .rdCtl, .rdData, .rdDlc, .rdRemote, .storeValid, .storeIdx, .lostEvent,
      .overrunIrq, .fifoRxValid(fifoRx), .rxCompleteVec, .msgLostVec, .abortBusyVec);
   task automatic tick(); @(posedge ref_clk); #1; endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic box(input logic [4:0] idx, input logic [28:0] id, input logic [7:0] c);
      {idWrIdx, idWrData, idWrEn} = {idx, id, 1'b1};
      tick();
      idWrEn = 1'b0;
      {ctlWrIdx, ctlWrData, ctlWrEn} = {idx, c, 1'b1};
      tick();
      ctlWrEn = 1'b0;
      tick();
   endtask
   task automatic fstart(input logic [28:0] id, input logic [63:0] d, input logic [3:0] len);
      {goId, goData, goLen, go} = {id, d, len, 1'b1};
      tick();
      go = 1'b0;
   endtask
   task automatic fwait();
      for (int k = 0; k < 40 && frmValid !== 1'b1; k++) tick();
      check(frmValid, 1, "frameEnd");
      tick();
   endtask
   task automatic send(input logic [28:0] id, input logic [63:0] d);
      fstart(id, d, 4'h2);
      fwait();
   endtask
   task automatic rd(input logic [4:0] idx); rdIdx = idx; tick(); endtask
   task automatic t_reset();
      check(rxCompleteVec, 0, "complete");
      check(msgLostVec, 0, "lost");
      rd(5'h03); check(rdCtl, 8'h00, "ctl");
   endtask
   task automatic t_lowest();
      box(5'h03, ID_A, 8'h80);
      box(5'h05, ID_A, 8'h80);
      goRemote = 1'b1;
      send(ID_A, 64'h1111);
      goRemote = 1'b0;
      check(storeValid, 1, "store");
      check(storeIdx, 3, "storeIdx");
      check(rxCompleteVec[3], 1, "complete3");
      rd(5'h03); check(rdRemote, 1, "remote");
      check(rdDlc, 4'h8, "dlc");
   endtask
   task automatic t_overwrite();
      lostMode = 1'b0;
      send(ID_A, 64'h2222);
      check(storeIdx, 3, "storeIdx");
      check(lostEvent, 1, "lostEvent");
      check(msgLostVec[3], 1, "lost3");
      rd(5'h03); check(rdData, 64'h2222, "data");
      check(rdCtl[0], 1, "completeBit");
      box(5'h03, ID_A, 8'h80);
      check(rxCompleteVec[3], 0, "cleared");
   endtask
   task automatic t_overrun();
      {lostMode, irqEn} = 2'b11;
      send(ID_A, 64'h3333);
      check(storeValid, 1, "store");
      send(ID_A, 64'h4444);
      check(storeValid, 0, "discard");
      check(overrunIrq, 1, "irq");
      check(msgLostVec[3], 1, "lost3");
      irqEn = 1'b0;
      send(ID_A, 64'h5555);
      check(overrunIrq, 0, "irqOff");
      rd(5'h03); check(rdData, 64'h3333, "kept");
   endtask
   task automatic t_single_shot_enable();
      lostMode = 1'b0;
      box(5'h08, ID_B, 8'h90);
      box(5'h09, ID_B, 8'h90);
      send(ID_B, 64'h6666);
      check(storeIdx, 8, "first");
      send(ID_B, 64'h7777);
      check(storeIdx, 9, "second");
      send(ID_B, 64'h8888);
      check(storeValid, 0, "full");
      check(msgLostVec[9:8], 0, "noLoss");
   endtask
   task automatic t_abort();
      box(5'h0C, ID_C, 8'h80);
      fstart(ID_C, 64'h9999, 4'h8);
      {ctlWrIdx, ctlWrData, ctlWrEn} = {5'h0C, 8'h00, 1'b1};
      tick();
      ctlWrEn = 1'b0;
      check(abortBusyVec[12], 1, "aborting");
      fwait();
      check(storeValid, 0, "noStore");
      tick();
      check(abortBusyVec[12], 0, "abortDone");
      box(5'h10, 29'h0000770, 8'h80);
      send(ID_C, 64'hDDDD);
      check(storeIdx, 16, "masked");
   endtask
   task automatic t_layout();
      box(5'h1C, ID_E, 8'h00);
      box(5'h1F, ID_E, 8'h80);
      box(5'h17, ID_F, 8'h80);
      layout = 1'b1;
      send(ID_E, 64'hAAAA);
      check(storeValid, 0, "fifoBox");
      check(fifoRx, 1, "fifoRx");
      send(ID_F, 64'hBBBB);
      check(storeIdx, 23, "ordinary");
      check(fifoRx, 0, "fifoOrd");
      layout = 1'b0;
      send(ID_E, 64'hCCCC);
      check(storeIdx, 31, "normal");
      check(rxCompleteVec[31], 1, "box31");
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      #1 rst = 1'b0;
      maskWrEn = 1'b1;
      for (int k = 0; k < 8; k++) begin
         maskWrIdx = 3'(k);
         maskData  = (k == 4) ? 29'h1FFFFFF0 : 29'h1FFFFFFF;
         tick();
      end
      maskWrEn = 1'b0;
      t_reset();
      t_lowest();
      t_overwrite();
      t_overrun();
      t_single_shot_enable();
      t_abort();
      t_layout();
      end_of_test();
   end
endmodule
`default_nettype wire
